// ==== core/pfc_cfg_pkg.sv ====
// Constants for the power factor correction configuration register bank.
// Assumes a register access port decoded from the management bus command layer.
package pfc_cfg_pkg;
  // Register offsets
  localparam logic [15:0] ADDR_FAST_OC      = 16'hFE3E;
  localparam logic [15:0] ADDR_TEMP_HYS     = 16'hFE3F;
  localparam logic [15:0] ADDR_LINE_TRIM    = 16'hFE40;
  localparam logic [15:0] ADDR_VOUT_TRIM    = 16'hFE41;
  localparam logic [15:0] ADDR_CS_TRIM      = 16'hFE42;
  localparam logic [15:0] ADDR_BAL_GAIN     = 16'hFE43;
  localparam logic [15:0] ADDR_LOW_POWER    = 16'hFE44;
  // Field positions
  localparam int LIMIT_HI          = 7;
  localparam int LIMIT_LO          = 5;
  localparam int LIMIT_NEG_BIT     = 7;
  localparam int CS_RANGE_BIT      = 1;
  localparam int REF_SEL_BIT       = 0;
  localparam int SIGN_BIT          = 7;
  localparam int BAL_EN_BIT        = 7;
  localparam int THRESH_MSB        = 12;
  // Writable masks; reserved bits stay zero
  localparam logic [7:0]  FAST_OC_MASK    = 8'hE3;
  localparam logic [15:0] LOW_POWER_MASK  = 16'h1FFF;
  // Reset values
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [15:0] RESET_WORD      = 16'h0000;
  // Peak limit table, microamps: positive then negative sensing
  localparam logic [7:0]  LIMIT_UA_POS_BASE = 8'd20;
  localparam logic [7:0]  LIMIT_UA_NEG_BASE = 8'd60;
  localparam logic [7:0]  LIMIT_UA_STEP     = 8'd20;
endpackage

// ==== core/pfc_sense_trim_config_regs.sv ====
// Configuration registers: fast overcurrent, temperature hysteresis, gain trims, phase balance, low power threshold.
// Assumes a single-cycle register write/read port from the command layer and sense values on the same clock.
// Operation
// - Bits 7:5 of the fast overcurrent register pick a peak limit of 20-80 uA positive or 60-120 uA negative.
// - Bit 0 of the fast overcurrent register picks resistor or bandgap reference for the level shift.
// - The overtemp fault flag clears only when temperature exceeds fault limit plus hysteresis.
// - The overtemp warning flag clears only when temperature exceeds warning limit plus hysteresis.
// - The three gain trim registers take writes only while the write lock is released.
// - Each trim has a sign in bit 7 (1 negative) and a magnitude in bits 6:0.
// - The first trim scales the line voltage sense path.
// - The second trim scales the output voltage feedback path.
// - The third trim scales the current sense path in its 500 mV range.
// - Balance enable 1 balances; writing 0 stops balancing and clears the integrator.
// - Balance gain is seven bits unsigned, 0 to 127.
// - With smart output voltage on and power below the threshold, regulate to the light load low or high line target.
// - Current sense above the peak limit longer than the debounce disables PWM for the rest of the cycle.
`timescale 1ns/1ns
module pfc_sense_trim_config_regs
  import pfc_cfg_pkg::*;
#(
  parameter int SENSE_W  = 16,
  parameter int TEMP_W   = 12,
  parameter int POWER_W  = 13,
  parameter int VOUT_W   = 11,
  parameter int DEBOUNCE_MAX = 15
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [15:0]        reg_addr,
  input  wire logic [15:0]        reg_wdata,
  output logic      [15:0]        reg_rdata,
  output logic                    reg_ack,
  input  wire logic               write_unlocked,
  input  wire logic [SENSE_W-1:0] line_voltage_sense,
  input  wire logic [SENSE_W-1:0] output_voltage_feedback,
  input  wire logic [SENSE_W-1:0] current_sense,
  output logic      [SENSE_W-1:0] line_voltage_trimmed,
  output logic      [SENSE_W-1:0] output_voltage_trimmed,
  output logic      [SENSE_W-1:0] current_sense_trimmed,
  input  wire logic [TEMP_W-1:0]  temperature_sense,
  input  wire logic               temp_sample,
  input  wire logic [TEMP_W-1:0]  temp_fault_limit,
  input  wire logic [TEMP_W-1:0]  temp_warning_limit,
  output logic                    overtemp_fault_flag,
  output logic                    overtemp_warning_flag,
  input  wire logic signed [15:0] balance_error,
  input  wire logic               balance_step,
  output logic signed [23:0]      balance_integrator,
  input  wire logic               smart_vout_enable,
  input  wire logic               high_line,
  input  wire logic [POWER_W-1:0] input_power,
  input  wire logic [VOUT_W-1:0]  low_line_light_load_vout,
  input  wire logic [VOUT_W-1:0]  high_line_light_load_vout,
  input  wire logic [VOUT_W-1:0]  normal_vout,
  output logic      [VOUT_W-1:0]  vout_target,
  output logic                    low_power_mode,
  input  wire logic               cycle_start,
  input  wire logic               overcurrent_compare,
  input  wire logic [3:0]         debounce_cycles,
  output logic                    pwm_disable,
  output logic      [2:0]         peak_current_limit,
  output logic      [7:0]         peak_limit_ua,
  output logic                    limit_negative,
  output logic                    level_shift_ref_select,
  output logic                    cs_range_500mv
);

  // Refuse widths and counts the logic cannot serve
  initial begin
    if (SENSE_W < 8 || TEMP_W < 8 || POWER_W != 13 || VOUT_W < 1)
      $error("pfc_sense_trim_config_regs: unsupported width parameters");
    if (DEBOUNCE_MAX < 1 || DEBOUNCE_MAX > 15)
      $error("pfc_sense_trim_config_regs: unsupported debounce range");
  end

  // Stored registers
  logic [7:0]  fast_overcurrent_setting, next_fast_overcurrent_setting;
  logic [7:0]  temperature_hysteresis,   next_temperature_hysteresis;
  logic [7:0]  line_voltage_gain_trim,   next_line_voltage_gain_trim;
  logic [7:0]  output_voltage_gain_trim, next_output_voltage_gain_trim;
  logic [7:0]  current_sense_gain_trim,  next_current_sense_gain_trim;
  logic [7:0]  phase_balance_gain,       next_phase_balance_gain;
  logic [15:0] smart_vout_low_power_threshold, next_smart_vout_low_power_threshold;
  logic [15:0] next_reg_rdata;
  logic        next_reg_ack;

  // Apply a signed trim: value * (1 +/- mag/1024), saturated
  function automatic logic [SENSE_W-1:0] apply_trim(input logic [SENSE_W-1:0] v, input logic [7:0] t);
    logic [SENSE_W+7:0] prod;
    logic [SENSE_W:0]   delta;
    logic [SENSE_W+1:0] sum;
    // Floor of the scaled product keeps the trim monotonic in the raw code
    prod  = {8'h00, v} * {{SENSE_W{1'b0}}, 1'b0, t[6:0]};
    delta = (SENSE_W+1)'(prod[SENSE_W+6:10]);
    sum   = '0;
    if (t[SIGN_BIT]) begin
      if ({1'b0, v} < delta) sum = '0;
      else sum = {1'b0, ({1'b0, v} - delta)};
    end else begin
      sum = {1'b0, ({1'b0, v} + delta)};
    end
    if (sum[SENSE_W+1:SENSE_W] != 2'b00) apply_trim = '1;
    else apply_trim = sum[SENSE_W-1:0];
  endfunction

  // Register writes and read mux
  always_comb begin
    next_fast_overcurrent_setting       = fast_overcurrent_setting;
    next_temperature_hysteresis         = temperature_hysteresis;
    next_line_voltage_gain_trim         = line_voltage_gain_trim;
    next_output_voltage_gain_trim       = output_voltage_gain_trim;
    next_current_sense_gain_trim        = current_sense_gain_trim;
    next_phase_balance_gain             = phase_balance_gain;
    next_smart_vout_low_power_threshold = smart_vout_low_power_threshold;
    next_reg_ack                        = reg_wr | reg_rd;
    next_reg_rdata                      = reg_rdata;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_FAST_OC:   next_fast_overcurrent_setting = reg_wdata[7:0] & FAST_OC_MASK;
        ADDR_TEMP_HYS:  next_temperature_hysteresis = reg_wdata[7:0];
        ADDR_LINE_TRIM: if (write_unlocked) next_line_voltage_gain_trim = reg_wdata[7:0];
        ADDR_VOUT_TRIM: if (write_unlocked) next_output_voltage_gain_trim = reg_wdata[7:0];
        ADDR_CS_TRIM:   if (write_unlocked) next_current_sense_gain_trim = reg_wdata[7:0];
        ADDR_BAL_GAIN:  next_phase_balance_gain = reg_wdata[7:0];
        ADDR_LOW_POWER: next_smart_vout_low_power_threshold = reg_wdata & LOW_POWER_MASK;
        default: ;
      endcase
    end
    // Read data is registered and holds; unmapped reads return zero
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_FAST_OC:   next_reg_rdata = {8'h00, fast_overcurrent_setting};
        ADDR_TEMP_HYS:  next_reg_rdata = {8'h00, temperature_hysteresis};
        ADDR_LINE_TRIM: next_reg_rdata = {8'h00, line_voltage_gain_trim};
        ADDR_VOUT_TRIM: next_reg_rdata = {8'h00, output_voltage_gain_trim};
        ADDR_CS_TRIM:   next_reg_rdata = {8'h00, current_sense_gain_trim};
        ADDR_BAL_GAIN:  next_reg_rdata = {8'h00, phase_balance_gain};
        ADDR_LOW_POWER: next_reg_rdata = smart_vout_low_power_threshold;
        default:        next_reg_rdata = RESET_WORD;
      endcase
    end
  end

  // Register file, read data and acknowledge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      fast_overcurrent_setting       <= RESET_BYTE;
      temperature_hysteresis         <= RESET_BYTE;
      line_voltage_gain_trim         <= RESET_BYTE;
      output_voltage_gain_trim       <= RESET_BYTE;
      current_sense_gain_trim        <= RESET_BYTE;
      phase_balance_gain             <= RESET_BYTE;
      smart_vout_low_power_threshold <= RESET_WORD;
      reg_rdata                      <= RESET_WORD;
      reg_ack                        <= 1'b0;
    end else begin
      fast_overcurrent_setting       <= next_fast_overcurrent_setting;
      temperature_hysteresis         <= next_temperature_hysteresis;
      line_voltage_gain_trim         <= next_line_voltage_gain_trim;
      output_voltage_gain_trim       <= next_output_voltage_gain_trim;
      current_sense_gain_trim        <= next_current_sense_gain_trim;
      phase_balance_gain             <= next_phase_balance_gain;
      smart_vout_low_power_threshold <= next_smart_vout_low_power_threshold;
      reg_rdata                      <= next_reg_rdata;
      reg_ack                        <= next_reg_ack;
    end
  end

  // Trimmed sense paths, limit decode and static selects
  logic [SENSE_W-1:0] next_line_trimmed, next_vout_trimmed, next_cs_trimmed;
  logic [7:0]         next_limit_ua;
  logic [2:0]         lim_code;
  // Decodes follow the next value so they line up with the acknowledge
  always_comb begin
    lim_code          = next_fast_overcurrent_setting[LIMIT_HI:LIMIT_LO];
    next_line_trimmed = apply_trim(line_voltage_sense, line_voltage_gain_trim);
    next_vout_trimmed = apply_trim(output_voltage_feedback, output_voltage_gain_trim);
    next_cs_trimmed   = cs_range_500mv ? apply_trim(current_sense, current_sense_gain_trim)
                                       : current_sense;
    next_limit_ua     = (lim_code[2] ? LIMIT_UA_NEG_BASE : LIMIT_UA_POS_BASE)
                        + LIMIT_UA_STEP * {6'h00, lim_code[1:0]};
  end

  // Registered trims and decodes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      line_voltage_trimmed   <= '0;
      output_voltage_trimmed <= '0;
      current_sense_trimmed  <= '0;
      peak_current_limit     <= 3'h0;
      peak_limit_ua          <= LIMIT_UA_POS_BASE;
      limit_negative         <= 1'b0;
      level_shift_ref_select <= 1'b0;
      cs_range_500mv         <= 1'b0;
    end else begin
      line_voltage_trimmed   <= next_line_trimmed;
      output_voltage_trimmed <= next_vout_trimmed;
      current_sense_trimmed  <= next_cs_trimmed;
      peak_current_limit     <= lim_code;
      peak_limit_ua          <= next_limit_ua;
      limit_negative         <= next_fast_overcurrent_setting[LIMIT_NEG_BIT];
      level_shift_ref_select <= next_fast_overcurrent_setting[REF_SEL_BIT];
      cs_range_500mv         <= next_fast_overcurrent_setting[CS_RANGE_BIT];
    end
  end

  // Overtemperature flags with release hysteresis
  logic            next_overtemp_fault_flag, next_overtemp_warning_flag;
  logic [TEMP_W:0] fault_release, warn_release;
  always_comb begin
    fault_release = {1'b0, temp_fault_limit} + {{(TEMP_W-7){1'b0}}, temperature_hysteresis};
    warn_release  = {1'b0, temp_warning_limit} + {{(TEMP_W-7){1'b0}}, temperature_hysteresis};
    next_overtemp_fault_flag = overtemp_fault_flag;
    next_overtemp_warning_flag  = overtemp_warning_flag;
    if (temp_sample) begin
      // Low reading means hot: set below limit, clear only past limit plus hysteresis
      if (temperature_sense < temp_fault_limit) next_overtemp_fault_flag = 1'b1;
      else if ({1'b0, temperature_sense} > fault_release) next_overtemp_fault_flag = 1'b0;
      if (temperature_sense < temp_warning_limit) next_overtemp_warning_flag = 1'b1;
      else if ({1'b0, temperature_sense} > warn_release) next_overtemp_warning_flag = 1'b0;
    end
  end

  // Registered overtemperature flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      overtemp_fault_flag   <= 1'b0;
      overtemp_warning_flag <= 1'b0;
    end else begin
      overtemp_fault_flag   <= next_overtemp_fault_flag;
      overtemp_warning_flag <= next_overtemp_warning_flag;
    end
  end

  // Phase current balance integrator
  logic signed [23:0] next_integrator;
  logic signed [23:0] bal_incr;
  always_comb begin
    bal_incr        = 24'(balance_error) * $signed({17'h0_0000, phase_balance_gain[6:0]});
    next_integrator = balance_integrator;
    if (!next_phase_balance_gain[BAL_EN_BIT]) next_integrator = '0;
    else if (balance_step) next_integrator = balance_integrator + bal_incr;
  end

  // Registered integrator
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) balance_integrator <= '0;
    else balance_integrator <= next_integrator;
  end

  // Smart output voltage selection
  logic [VOUT_W-1:0] next_vout_target;
  logic              next_low_power;
  always_comb begin
    next_low_power   = smart_vout_enable &&
                       (input_power < smart_vout_low_power_threshold[THRESH_MSB:0]);
    next_vout_target = normal_vout;
    if (next_low_power)
      next_vout_target = high_line ? high_line_light_load_vout : low_line_light_load_vout;
  end

  // Registered output voltage target and mode
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      vout_target    <= '0;
      low_power_mode <= 1'b0;
    end else begin
      vout_target    <= next_vout_target;
      low_power_mode <= next_low_power;
    end
  end

  // Cycle-by-cycle peak current shutdown after debounce
  logic       oc_meta, oc_sync;
  logic [3:0] oc_count, next_oc_count;
  logic       next_pwm_disable;
  // Saturating count so a long overcurrent never wraps and re-arms the debounce
  always_comb begin
    next_oc_count    = oc_sync ? ((oc_count == 4'(DEBOUNCE_MAX)) ? oc_count : oc_count + 4'h1) : 4'h0;
    next_pwm_disable = pwm_disable;
    if (cycle_start) next_pwm_disable = 1'b0;
    else if (oc_sync && oc_count >= debounce_cycles) next_pwm_disable = 1'b1;
  end

  // Comparator synchroniser, debounce counter and shutdown flag
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      oc_meta     <= 1'b0;
      oc_sync     <= 1'b0;
      oc_count    <= 4'h0;
      pwm_disable <= 1'b0;
    end else begin
      oc_meta     <= overcurrent_compare;
      oc_sync     <= oc_meta;
      oc_count    <= next_oc_count;
      pwm_disable <= next_pwm_disable;
    end
  end

endmodule

// ==== verification/pfc_cfg_assertions.sv ====
// Port checker for the configuration register bank.
// Assumes it is bound into the bank and sees only the bank's own ports.
`timescale 1ns/1ns
module pfc_cfg_assertions
  import pfc_cfg_pkg::*;
(
  input wire logic               clk,
  input wire logic               nrst,
  input wire logic               reg_wr,
  input wire logic               reg_rd,
  input wire logic [15:0]        reg_addr,
  input wire logic [15:0]        reg_wdata,
  input wire logic [15:0]        reg_rdata,
  input wire logic               reg_ack,
  input wire logic signed [23:0] balance_integrator,
  input wire logic [2:0]         peak_current_limit,
  input wire logic [7:0]         peak_limit_ua,
  input wire logic               limit_negative,
  input wire logic               level_shift_ref_select,
  input wire logic               cs_range_500mv
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Write to the fast overcurrent register
  sequence s_fast_wr;
    reg_wr && reg_addr == ADDR_FAST_OC;
  endsequence
  // Write that clears the balance enable bit
  sequence s_bal_off;
    reg_wr && reg_addr == ADDR_BAL_GAIN && !reg_wdata[BAL_EN_BIT];
  endsequence
  property p_ack;
    (reg_wr || reg_rd) |=> reg_ack; endproperty
  a_ack: assert property (p_ack) else $error("request without acknowledge");
  property p_rsvd_byte;
    reg_rd && reg_addr inside {[ADDR_FAST_OC:ADDR_BAL_GAIN]} |=> reg_rdata[15:8] == 8'h00; endproperty
  a_rsvd_byte: assert property (p_rsvd_byte) else $error("byte register upper half not zero");
  property p_rsvd_fast;
    reg_rd && reg_addr == ADDR_FAST_OC |=> reg_rdata[4:2] == 3'h0; endproperty
  a_rsvd_fast: assert property (p_rsvd_fast) else $error("fast overcurrent reserved bits set");
  property p_rsvd_word;
    reg_rd && reg_addr == ADDR_LOW_POWER |=> reg_rdata[15:13] == 3'h0; endproperty
  a_rsvd_word: assert property (p_rsvd_word) else $error("threshold reserved bits set");
  property p_unmapped;
    reg_rd && !(reg_addr inside {[ADDR_FAST_OC:ADDR_LOW_POWER]}) |=> reg_rdata == 16'h0000; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_limit_tbl;
    peak_limit_ua == (limit_negative ? 8'h3C : 8'h14) + 8'h14 * peak_current_limit[1:0]
      && limit_negative == peak_current_limit[2]; endproperty
  a_limit_tbl: assert property (p_limit_tbl) else $error("peak limit decode wrong");
  property p_fast_wr;
    s_fast_wr |=> peak_current_limit == $past(reg_wdata[7:5]) && level_shift_ref_select == $past(reg_wdata[0])
      && cs_range_500mv == $past(reg_wdata[1]); endproperty
  a_fast_wr: assert property (p_fast_wr) else $error("fast overcurrent fields not taken");
  property p_bal_clr;
    s_bal_off |=> balance_integrator == 24'h00_0000; endproperty
  a_bal_clr: assert property (p_bal_clr) else $error("integrator not cleared");
endmodule

// ==== verification/pfc_host_model.sv ====
// Host side of the register port: single-cycle strobes, answer by reg_ack.
// Assumes the bank takes a strobe at one rising edge and raises reg_ack at that same edge.
`timescale 1ns/1ns
module pfc_host_model (
  input  wire logic        clk,
  input  wire logic        reg_ack,
  input  wire logic [15:0] reg_rdata,
  output logic             reg_wr,
  output logic             reg_rd,
  output logic      [15:0] reg_addr,
  output logic      [15:0] reg_wdata,
  output logic             write_unlocked
);
  // Idle port and locked trims at time zero
  initial begin
    {reg_wr, reg_rd, write_unlocked, reg_addr, reg_wdata} = '0;
  end
  // One access; address and data held until the answer, then scrambled
  task automatic access(input logic is_wr, input logic [15:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    int n;
    @(posedge clk);
    #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = is_wr;
    reg_rd = !is_wr;
    @(posedge clk);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    for (n = 0; n < 8 && reg_ack !== 1'b1; n++) begin
      @(posedge clk);
      #1;
    end
    ok = (reg_ack === 1'b1);
    q = reg_rdata;
    // Let the answer edge pass before the port changes
    @(posedge clk);
    #1;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  // Lock control; trim writes are only meant after a release
  task automatic unlock(input logic u);
    @(posedge clk);
    #1;
    write_unlocked = u;
  endtask
endmodule

// ==== verification/pfc_sense_trim_config_regs_tb.sv ====
// Self-checking bench for the configuration register bank.
// Assumes the host model drives the register port; outputs are compared with a bench model.
`timescale 1ns/1ns
module pfc_sense_trim_config_regs_tb
  import pfc_cfg_pkg::*;
;
  logic        clk, nrst, reg_wr, reg_rd, reg_ack, write_unlocked, temp_sample, overtemp_fault_flag, ok;
  logic        overtemp_warning_flag, balance_step, smart_vout_enable, high_line, low_power_mode, cycle_start;
  logic        overcurrent_compare, pwm_disable, limit_negative, level_shift_ref_select, cs_range_500mv;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, line_voltage_sense, output_voltage_feedback, current_sense, q;
  logic [15:0] line_voltage_trimmed, output_voltage_trimmed, current_sense_trimmed, balance_error;
  logic [11:0] temperature_sense, temp_fault_limit, temp_warning_limit;
  logic [23:0] balance_integrator;
  logic [12:0] input_power;
  logic [10:0] low_line_light_load_vout, high_line_light_load_vout, normal_vout, vout_target;
  logic [7:0]  peak_limit_ua;
  logic [3:0]  debounce_cycles;
  logic [2:0]  peak_current_limit;
  int          error_cnt, samples_checked, seed, i, f, w, lp;
  int          mdl[8];
  int          tvals[8] = '{900, 1020, 1021, 1400, 1520, 1521, 1400, 900};
  pfc_sense_trim_config_regs u_dut (.*);
  pfc_host_model u_host (.*);
  // Free-running 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic int mask(int a);
    return a == ADDR_FAST_OC ? FAST_OC_MASK : a == ADDR_LOW_POWER ? LOW_POWER_MASK : 255;
  endfunction
  // Gain trim: sign in bit 7, magnitude in 1/1024 steps, saturating
  function automatic int trim(int v, int t);
    int r;
    r = t[7] ? v - v * (t & 127) / 1024 : v + v * (t & 127) / 1024;
    return r > 65535 ? 65535 : r;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Access with a bounded wait for the answer
  task automatic go(logic is_wr, logic [15:0] a, logic [15:0] d);
    u_host.access(is_wr, a, d, q, ok);
    if (ok !== 1'b1) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic wr(logic [15:0] a, int d);
    go(1'b1, a, 16'(d));
    if (write_unlocked || a < ADDR_LINE_TRIM || a > ADDR_CS_TRIM)
      mdl[a - ADDR_FAST_OC] = d & mask(a);
  endtask
  task automatic rdchk(logic [15:0] a);
    go(1'b0, a, 16'h0000);
    check("reg_rdata", q, mdl[a - ADDR_FAST_OC]);
  endtask
  // Main sequence
  initial begin
    seed = 80006;
    {nrst, temp_sample, balance_step, smart_vout_enable, high_line, cycle_start, overcurrent_compare} = '0;
    {line_voltage_sense, output_voltage_feedback, current_sense, balance_error, input_power} = '0;
    {temperature_sense, temp_fault_limit, temp_warning_limit, debounce_cycles} = '0;
    {low_line_light_load_vout, high_line_light_load_vout, normal_vout} = '0;
    tick(6);
    nrst = 1'b1;
    check("peak_limit_ua", peak_limit_ua, 20);
    for (i = 0; i < 8; i++)
      rdchk(16'(ADDR_FAST_OC + i));
    u_host.unlock(1'b1);
    for (i = 0; i < 7; i++) begin
      wr(16'(ADDR_FAST_OC + i), $random(seed));
      rdchk(16'(ADDR_FAST_OC + i));
    end
    u_host.unlock(1'b0);
    for (i = 2; i < 5; i++) begin
      wr(16'(ADDR_FAST_OC + i), $random(seed));
      rdchk(16'(ADDR_FAST_OC + i));
    end
    for (i = 0; i < 8; i++) begin
      wr(ADDR_FAST_OC, {i[2:0], 3'b111, i[1:0]});
      check("peak_current_limit", peak_current_limit, i[2:0]);
      check("peak_limit_ua", peak_limit_ua, (i[2] ? 60 : 20) + 20 * i[1:0]);
      check("limit_negative", limit_negative, i[2]);
      check("level_shift_ref_select", level_shift_ref_select, i[0]);
      check("cs_range_500mv", cs_range_500mv, i[1]);
      rdchk(ADDR_FAST_OC);
    end
    u_host.unlock(1'b1);
    for (i = 0; i < 6; i++) begin
      wr(ADDR_FAST_OC, i[0] << 1);
      for (f = 2; f < 5; f++)
        wr(16'(ADDR_FAST_OC + f), $random(seed));
      line_voltage_sense = 16'(($random(seed) & 63) << 10);
      output_voltage_feedback = 16'(($random(seed) & 63) << 10);
      current_sense = 16'(($random(seed) & 63) << 10);
      tick(2);
      check("line_trim", line_voltage_trimmed, trim(line_voltage_sense, mdl[2]));
      check("vout_trim", output_voltage_trimmed, trim(output_voltage_feedback, mdl[3]));
      check("cs_trim", current_sense_trimmed, i[0] ? trim(current_sense, mdl[4]) : current_sense);
    end
    wr(ADDR_TEMP_HYS, 20);
    temp_fault_limit = 12'd1000;
    temp_warning_limit = 12'd1500;
    f = 0;
    w = 0;
    for (i = 0; i < 8; i++) begin
      temperature_sense = 12'(tvals[i]);
      temp_sample = 1'b1;
      f = tvals[i] < 1000 ? 1 : tvals[i] > 1000 + mdl[1] ? 0 : f;
      w = tvals[i] < 1500 ? 1 : tvals[i] > 1500 + mdl[1] ? 0 : w;
      tick(1);
      temp_sample = 1'b0;
      tick(1);
      check("overtemp_fault_flag", overtemp_fault_flag, f);
      check("overtemp_warning_flag", overtemp_warning_flag, w);
    end
    wr(ADDR_BAL_GAIN, 16'h00C0);
    balance_error = 16'h03E8;
    balance_step = 1'b1;
    tick(4);
    check("balance_integrator", balance_integrator, 4 * 1000 * (mdl[5] & 127));
    wr(ADDR_BAL_GAIN, 16'h0040);
    tick(1);
    check("balance_integrator", balance_integrator, 0);
    balance_step = 1'b0;
    wr(ADDR_LOW_POWER, 16'hE800);
    for (i = 0; i < 12; i++) begin
      {smart_vout_enable, high_line} = 2'($random(seed));
      input_power = 13'(2048 + (i == 0 ? 0 : $random(seed) % 64));
      {low_line_light_load_vout, high_line_light_load_vout, normal_vout} = 33'({$random(seed), $random(seed)});
      tick(2);
      lp = smart_vout_enable && input_power < mdl[6];
      check("low_power_mode", low_power_mode, lp);
      check("vout_target", vout_target,
            !lp ? normal_vout : high_line ? high_line_light_load_vout : low_line_light_load_vout);
    end
    debounce_cycles = 4'h3;
    overcurrent_compare = 1'b1;
    tick(1);
    overcurrent_compare = 1'b0;
    tick(6);
    check("pwm_disable", pwm_disable, 0);
    overcurrent_compare = 1'b1;
    tick(10);
    overcurrent_compare = 1'b0;
    tick(4);
    check("pwm_disable", pwm_disable, 1);
    cycle_start = 1'b1;
    tick(1);
    cycle_start = 1'b0;
    tick(1);
    check("pwm_disable", pwm_disable, 0);
    conclude();
  end
endmodule
bind pfc_sense_trim_config_regs pfc_cfg_assertions u_chk (.*);
